// ### design/eew_slave.sv
// Two-wire bus slave write path with page buffer and programming cycle
`timescale 1ns/1ns
module eew_slave
    import eew_pkg::*;
#(
    parameter int PROG_CYCLES = INTERNAL_PROGRAM_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por_ok,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic chip_select_strap_0,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_2,
    input wire logic write_guard,
    output logic prog_busy,
    output logic mem_wr_en,
    output eew_mem_wr_t mem_wr
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] sync_in;
    logic scl_s, sda_s, scl_d_reg, sda_d_reg;
    logic scl_rise, scl_fall, start_det, stop_det, por_low;
    logic [STRAP_W-1:0] straps;
    eew_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic byte_done_reg;
    logic [BYTE_W-1:0] shift_reg;
    logic [1:0] byte_idx_reg;
    logic is_write_reg, wp_latched_reg, loaded_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [BYTE_W-1:0] buf_reg [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] valid_reg;
    logic prog_busy_reg;
    logic [CNT_W-1:0] prog_cnt_reg;
    logic [OFFSET_W:0] commit_idx_reg;
    logic [PAGE_W-1:0] commit_page_reg;
    logic take, ack_now, accept_data, prog_start, prog_done;

    // ==========================================================
    // Input synchronisation
    assign raw_in = {por_ok, write_guard, chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
                     sda_in, scl_in};

    // Floating straps and guard settle low in the synchroniser
    eew_sync #(.W(IN_W)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(raw_in),
        .q(sync_in)
    );

    assign scl_s = sync_in[IN_SCL];
    assign sda_s = sync_in[IN_SDA];
    assign straps = sync_in[IN_STRAP +: STRAP_W];
    assign por_low = !sync_in[IN_POR];

    // Previous line levels for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // ==========================================================
    // Bus event decode
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // Acknowledge decision for the byte just received
    always_comb
    begin
        case (byte_idx_reg)
            IDX_DEV: ack_now = (shift_reg[7:4] == DEV_TYPE_CODE) && (shift_reg[3:1] == straps)
                               && !prog_busy_reg;
            IDX_ADDR_HI: ack_now = 1'b1;
            IDX_ADDR_LO: ack_now = 1'b1;
            default: ack_now = !wp_latched_reg;
        endcase
    end

    assign take = scl_fall && byte_done_reg && (state_reg == ST_RECV);
    assign accept_data = take && ack_now && (byte_idx_reg == IDX_DATA);
    assign prog_start = stop_det && is_write_reg && loaded_reg && !prog_busy_reg;
    assign prog_done = prog_busy_reg && (prog_cnt_reg == CNT_W'(PROG_CYCLES - 1));

    // ==========================================================
    // Command sequencer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            byte_idx_reg <= IDX_DEV;
        end
        else if (por_low)
        begin
            state_reg <= ST_IDLE;
            byte_idx_reg <= IDX_DEV;
        end
        else if (start_det)
        begin
            state_reg <= ST_RECV;
            byte_idx_reg <= IDX_DEV;
        end
        else if (stop_det)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            case (state_reg)
                ST_RECV:
                begin
                    if (take)
                    begin
                        state_reg <= ack_now ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        // Read direction is served elsewhere; this path steps aside
                        state_reg <= (byte_idx_reg == IDX_DEV && shift_reg[0]) ? ST_IGNORE : ST_RECV;
                        if (byte_idx_reg != IDX_DATA)
                        begin
                            byte_idx_reg <= byte_idx_reg + 2'h1;
                        end
                    end
                end
                default:
                begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // ==========================================================
    // Bit receiver, sampling on rising clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            shift_reg <= 8'h00;
        end
        else if (por_low || start_det || state_reg != ST_RECV)
        begin
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
        end
        else if (scl_rise)
        begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_done_reg <= (bit_cnt_reg == BIT_LAST);
        end
        else if (take)
        begin
            byte_done_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Open-drain data drive, enabled on falling clock only; also released by START, STOP, busy or low supply
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (por_low || start_det || stop_det || prog_busy_reg)
        begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (take && ack_now)
        begin
            sda_oe_n <= 1'b0;
        end
        else if (state_reg == ST_ACK && scl_fall)
        begin
            sda_oe_n <= 1'b1;
        end
    end

    // ==========================================================
    // Direction, guard strobe and address assembly
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            is_write_reg <= 1'b0;
            wp_latched_reg <= 1'b0;
            addr_reg <= 12'h000;
        end
        else if (por_low)
        begin
            is_write_reg <= 1'b0;
            wp_latched_reg <= 1'b0;
        end
        else if (start_det)
        begin
            is_write_reg <= 1'b0;
            wp_latched_reg <= 1'b0;
        end
        else
        begin
            if (take && ack_now && byte_idx_reg == IDX_DEV)
            begin
                is_write_reg <= !shift_reg[0];
            end
            if (state_reg == ST_ACK && scl_fall && byte_idx_reg == IDX_ADDR_LO)
            begin
                wp_latched_reg <= sync_in[IN_GUARD];
            end
            if (take && byte_idx_reg == IDX_ADDR_HI)
            begin
                addr_reg[11:8] <= shift_reg[3:0];
            end
            if (take && byte_idx_reg == IDX_ADDR_LO)
            begin
                addr_reg[7:0] <= shift_reg;
            end
            if (accept_data)
            begin
                addr_reg[OFFSET_W-1:0] <= addr_reg[OFFSET_W-1:0] + 5'h01;
            end
        end
    end

    // ==========================================================
    // Page buffer load
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            valid_reg <= '0;
            loaded_reg <= 1'b0;
            for (int k = 0; k < PAGE_BYTES; k++)
            begin
                buf_reg[k] <= 8'hFF;
            end
        end
        else if (por_low || prog_done || (start_det && !prog_busy_reg))
        begin
            valid_reg <= '0;
            loaded_reg <= 1'b0;
        end
        else if (accept_data)
        begin
            buf_reg[addr_reg[OFFSET_W-1:0]] <= shift_reg;
            valid_reg[addr_reg[OFFSET_W-1:0]] <= 1'b1;
            loaded_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Programming cycle timer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prog_busy_reg <= 1'b0;
            prog_cnt_reg <= '0;
        end
        else if (por_low)
        begin
            prog_busy_reg <= 1'b0;
            prog_cnt_reg <= '0;
        end
        else if (prog_start)
        begin
            prog_busy_reg <= 1'b1;
            prog_cnt_reg <= '0;
        end
        else if (prog_done)
        begin
            prog_busy_reg <= 1'b0;
        end
        else if (prog_busy_reg)
        begin
            prog_cnt_reg <= prog_cnt_reg + CNT_W'(1);
        end
    end

    assign prog_busy = prog_busy_reg;

    // ==========================================================
    // Commit of loaded bytes to the array, one slot per cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            commit_idx_reg <= 6'h20;
            commit_page_reg <= '0;
            mem_wr_en <= 1'b0;
            mem_wr <= '0;
        end
        else if (por_low)
        begin
            commit_idx_reg <= 6'h20;
            mem_wr_en <= 1'b0;
        end
        else if (prog_start)
        begin
            commit_idx_reg <= 6'h00;
            commit_page_reg <= addr_reg[ADDR_W-1:OFFSET_W];
            mem_wr_en <= 1'b0;
        end
        else if (prog_busy_reg && !commit_idx_reg[OFFSET_W])
        begin
            mem_wr_en <= valid_reg[commit_idx_reg[OFFSET_W-1:0]];
            mem_wr.addr <= {commit_page_reg, commit_idx_reg[OFFSET_W-1:0]};
            mem_wr.data <= buf_reg[commit_idx_reg[OFFSET_W-1:0]];
            commit_idx_reg <= commit_idx_reg + 6'h01;
        end
        else
        begin
            mem_wr_en <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_busy_floats: assert property (prog_busy_reg |=> sda_oe_n) else $error("data driven while programming");
    a_drive_on_fall: assert property ($fell(sda_oe_n) |-> $past(scl_fall)) else $error("drive not on fall");
    a_start_recv: assert property (start_det && !por_low |=> state_reg == ST_RECV && byte_idx_reg == IDX_DEV)
        else $error("start not taken");
    a_stop_idle: assert property (stop_det && !start_det && !por_low |=> state_reg == ST_IDLE)
        else $error("stop not taken");
    a_addr_nack: assert property (take && byte_idx_reg == IDX_DEV && shift_reg[7:4] != DEV_TYPE_CODE
        |=> sda_oe_n && state_reg == ST_IGNORE) else $error("foreign address acknowledged");
    a_guard_reject: assert property (take && byte_idx_reg == IDX_DATA && wp_latched_reg
        |=> sda_oe_n && !loaded_reg) else $error("guarded write accepted");
    a_offset_wrap: assert property (accept_data && !por_low |=> addr_reg[OFFSET_W-1:0] ==
        $past(addr_reg[OFFSET_W-1:0]) + 5'h01 && addr_reg[ADDR_W-1:OFFSET_W] == $past(addr_reg[ADDR_W-1:OFFSET_W]))
        else $error("page offset step wrong");
    a_prog_launch: assert property (prog_start && !por_low |=> prog_busy_reg [*8])
        else $error("programming not started");
    a_commit_page: assert property (mem_wr_en |-> mem_wr.addr[ADDR_W-1:OFFSET_W] == commit_page_reg)
        else $error("commit outside page");
    a_por_hold: assert property (por_low |=> state_reg == ST_IDLE && !prog_busy_reg && sda_oe_n)
        else $error("logic not held under low supply");

    c_byte_write: cover property (prog_start);
    c_commit: cover property (mem_wr_en);
    c_guard_block: cover property (take && byte_idx_reg == IDX_DATA && wp_latched_reg);
    c_busy_poll: cover property (take && byte_idx_reg == IDX_DEV && prog_busy_reg);

endmodule

// ### shared/eew_pkg.sv
// Shared constants, types and state encoding for the two-wire memory write front end
package eew_pkg;

    // ==========================================================
    // Bus addressing
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 12;
    localparam int STRAP_W = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ==========================================================
    // Byte position within a command
    localparam logic [1:0] IDX_DEV = 2'h0;
    localparam logic [1:0] IDX_ADDR_HI = 2'h1;
    localparam logic [1:0] IDX_ADDR_LO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;

    // ==========================================================
    // Page buffer layout
    localparam int PAGE_BYTES = 32;
    localparam int OFFSET_W = 5;
    localparam int PAGE_W = ADDR_W - OFFSET_W;

    // ==========================================================
    // Programming time
    localparam int CLK_MHZ = 125;
    localparam int INTERNAL_PROGRAM_TIME_MS = 5;
    localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Positions in the synchronised input vector
    localparam int IN_SCL = 0;
    localparam int IN_SDA = 1;
    localparam int IN_STRAP = 2;
    localparam int IN_GUARD = 5;
    localparam int IN_POR = 6;
    localparam int IN_W = 7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_ACK, ST_IGNORE} eew_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } eew_mem_wr_t;

endpackage

// ### design/eew_sync.sv
// Two-flop input synchroniser bank; undriven inputs settle low
`timescale 1ns/1ns
module eew_sync
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // ==========================================================
    // One two-flop chain per bit
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // A floating or unknown level is taken as low
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    meta_reg[i] <= 1'b0;
                    q[i] <= 1'b0;
                end
                else
                begin
                    meta_reg[i] <= (d[i] == 1'b1) ? 1'b1 : 1'b0;
                    q[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule

// ### sim/eew_master_model.sv
// Two-wire bus master model: makes the link clock and drives data open-drain
`timescale 1ns/1ns
module eew_master_model
(
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Idle bus: clock high, data left to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // ==========================================
    // Bus conditions
    // START from a free bus, or a repeated START from a low clock
    task automatic bus_start();
        if (scl === 1'b1)
        begin
            wait (sda === 1'b1);
        end
        else
        begin
            sda_low = 1'b0;
            #31;
            scl = 1'b1;
        end
        #32;
        sda_low = 1'b1;
        #31;
        scl = 1'b0;
        #31;
    endtask

    // STOP: data rises while the clock is high, then a free-bus gap
    task automatic bus_stop();
        sda_low = 1'b1;
        #31;
        scl = 1'b1;
        #32;
        sda_low = 1'b0;
        #200;
    endtask

    // ==========================================
    // Byte transfer
    // Data moves only mid-way through the low phase
    task automatic put_bit(input logic b);
        sda_low = ~b;
        #31;
        scl = 1'b1;
        #63;
        scl = 1'b0;
        #31;
    endtask

    // Eight bits msb first, then release data and sample the ninth clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(b[i]);
        end
        sda_low = 1'b0;
        #31;
        scl = 1'b1;
        #32;
        ack = (sda === 1'b0);
        #31;
        scl = 1'b0;
        #31;
    endtask
endmodule

// ### sim/tb_eew_slave.sv
// Self-checking bench for the two-wire memory write front end
`timescale 1ns/1ns
module tb_eew_slave
    import eew_pkg::*;
;
    localparam int PROG = 1000;
    localparam int LIMIT = 40000;
    logic clk;
    logic rst;
    logic por_ok;
    logic [2:0] strap;
    logic write_guard;
    logic scl;
    logic sda_low;
    wire sda;
    logic sda_out;
    logic sda_oe_n;
    logic prog_busy;
    logic mem_wr_en;
    eew_mem_wr_t mem_wr;
    eew_mem_wr_t wr_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int busy_len = 0;
    int cyc = 0;

    // Wired-and data line with pull-up
    assign sda = (sda_low || (sda_oe_n === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;

    eew_slave #(.PROG_CYCLES(PROG)) uut
    (
        .clk(clk), .rst(rst), .por_ok(por_ok), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_strap_0(strap[0]),
        .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
        .write_guard(write_guard), .prog_busy(prog_busy), .mem_wr_en(mem_wr_en), .mem_wr(mem_wr)
    );

    eew_master_model u_master (.sda(sda), .scl(scl), .sda_low(sda_low));

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever
        begin
            #4 clk = ~clk;
        end
    end

    // Collect committed bytes, measure busy length, cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (mem_wr_en === 1'b1)
            wr_q.push_back(mem_wr);
        if (prog_busy === 1'b1)
            busy_len++;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================
    // Helpers
    // Send one byte and compare the acknowledge with the expectation
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.send_byte(b, a);
        check({31'h0, a}, {31'h0, exp_ack});
    endtask

    function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
        return {DEV_TYPE_CODE, s, rd};
    endfunction

    // Whole write: address bytes, n data bytes counting up from d0, STOP
    task automatic wr_cmd(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d0, input int n);
        u_master.bus_start();
        tx(dev(3'h5, 1'b0), 1'b1);
        tx(hi, 1'b1);
        tx(lo, 1'b1);
        for (int k = 0; k < n; k++)
            tx(d0 + k[7:0], 1'b1);
        u_master.bus_stop();
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (prog_busy !== 1'b0 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // ==========================================
    // Scenarios
    // Byte clocked in without a START is ignored
    task automatic t_no_start();
        tx(dev(3'h5, 1'b0), 1'b0);
        u_master.bus_stop();
    endtask

    // Wrong addresses refused, floating straps read low, read direction acked
    task automatic t_address();
        logic [7:0] bad [4];
        bad = '{8'hA8, 8'hAE, 8'hBA, 8'h2A};
        foreach (bad[i])
        begin
            u_master.bus_start();
            tx(bad[i], 1'b0);
            u_master.bus_stop();
        end
        @(negedge clk);
        strap = 3'bzz1;
        repeat (4) @(negedge clk);
        u_master.bus_start();
        tx(dev(3'h1, 1'b1), 1'b1);
        u_master.bus_stop();
        @(negedge clk);
        strap = 3'h5;
        repeat (4) @(negedge clk);
        check({31'h0, prog_busy}, 32'h0);
    endtask

    task automatic t_byte_write();
        wr_q.delete();
        busy_len = 0;
        wr_cmd(8'hF1, 8'h23, 8'h5A, 1);
        check({31'h0, prog_busy}, 32'h1);
        check({31'h0, sda_out}, 32'h0);
        wait_idle();
        check(wr_q.size(), 32'h1);
        check({12'h0, wr_q[0]}, {12'h0, 12'h123, 8'h5A});
        check(busy_len, PROG);
    endtask

    // Address refused while programming; master repeats until accepted
    task automatic t_poll();
        logic ack;
        int tries;
        tries = 0;
        wr_cmd(8'h00, 8'h40, 8'h11, 1);
        u_master.bus_start();
        u_master.send_byte(dev(3'h5, 1'b0), ack);
        check({31'h0, ack}, 32'h0);
        while (!ack && tries < 20)
        begin
            u_master.bus_stop();
            u_master.bus_start();
            u_master.send_byte(dev(3'h5, 1'b0), ack);
            tries++;
        end
        check({31'h0, ack}, 32'h1);
        check({31'h0, prog_busy}, 32'h0);
        u_master.bus_stop();
    endtask

    // Start at offset 30, 34 bytes: wrap inside the page, later bytes win
    task automatic t_page_wrap();
        int k;
        wr_q.delete();
        wr_cmd(8'h00, 8'h5E, 8'h40, 34);
        wait_idle();
        check(wr_q.size(), 32'd32);
        for (int o = 0; o < 32; o++)
        begin
            k = (o + 2) % 32;
            k = (k < 2) ? k + 32 : k;
            check({12'h0, wr_q[o]}, {12'h0, 12'h040 + o[11:0], 8'h40 + k[7:0]});
        end
    endtask

    // Guard high: first data byte refused, nothing programmed
    task automatic t_guard();
        wr_q.delete();
        @(negedge clk);
        write_guard = 1'b1;
        repeat (4) @(negedge clk);
        u_master.bus_start();
        tx(dev(3'h5, 1'b0), 1'b1);
        tx(8'h00, 1'b1);
        tx(8'h80, 1'b1);
        tx(8'h33, 1'b0);
        u_master.bus_stop();
        repeat (50) @(negedge clk);
        check({31'h0, prog_busy}, 32'h0);
        check(wr_q.size(), 32'h0);
        write_guard = 1'bz;
    endtask

    // Supply drop mid-programming returns to reset, then service resumes
    task automatic t_por();
        wr_cmd(8'h00, 8'h10, 8'h77, 1);
        repeat (40) @(negedge clk);
        por_ok = 1'b0;
        repeat (5) @(negedge clk);
        check({30'h0, prog_busy, sda_oe_n}, 32'h1);
        por_ok = 1'b1;
        repeat (4) @(negedge clk);
        wr_q.delete();
        wr_cmd(8'h00, 8'h10, 8'h78, 1);
        wait_idle();
        check({12'h0, wr_q[0]}, {12'h0, 12'h010, 8'h78});
    endtask

    initial
    begin
        rst = 1'b1;
        por_ok = 1'b1;
        strap = 3'h5;
        write_guard = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_no_start();
        t_address();
        t_byte_write();
        t_poll();
        t_page_wrap();
        t_guard();
        t_por();
        results();
    end
endmodule
